// [design/pfs_status.sv]
/*
 * status flags behind the profile feedback and generic flag read messages.
 * assumes: frames arrive as one-cycle strobes from a same-clock shifter; detection
 * events are one-cycle pulses from same-clock logic; enable and reset pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
module pfs_status #(
   parameter int NUM_CHANNELS = pfs_pkg::NUM_CHANNELS
) (
   input wire logic clk_in, // 250 MHz system clock
   input wire logic nrst_in, // async reset, active low
   input wire logic req_valid_in, // one-cycle frame strobe
   input wire logic [pfs_pkg::FRAME_W-1:0] req_frame_in, // received frame
   output logic resp_valid_out, // one-cycle answer strobe
   output logic [pfs_pkg::FRAME_W-1:0] resp_frame_out, // answer frame
   input wire logic [NUM_CHANNELS-1:0] gate_off_abort_in, // gate off during detection, pulse
   input wire logic [NUM_CHANNELS-1:0] timeout_expired_in, // timer expired during detection, pulse
   input wire logic [NUM_CHANNELS-1:0] detect_done_in, // detection sequence completed, pulse
   input wire logic overvoltage_evt_in, // overvoltage seen, pulse
   input wire logic phase_sync_evt_in, // phase sync event, pulse
   input wire logic enable_pin_in, // enable pin, async level
   input wire logic reset_pin_in // reset pin, async level, active low
);
   function automatic logic is_feedback(input logic [pfs_pkg::FRAME_W-1:0] f);
      pfs_pkg::pfs_frame_type fr;
      fr = f;
      return fr.message_identifier == pfs_pkg::MSG_PROFILE_FEEDBACK;
   endfunction

   function automatic logic is_generic(input logic [pfs_pkg::FRAME_W-1:0] f);
      pfs_pkg::pfs_frame_type fr;
      fr = f;
      return fr.message_identifier == pfs_pkg::MSG_GENERIC_FLAGS;
   endfunction

   pfs_pkg::pfs_frame_type req;
   assign req = req_frame_in;
   logic fb_read;
   logic gf_read;
   assign fb_read = req_valid_in && is_feedback(req_frame_in);
   assign gf_read = req_valid_in && is_generic(req_frame_in);

   // pin synchronisers; first stage read only by second
   logic en_s1_reg;
   logic en_s2_reg;
   logic rp_s1_reg;
   logic rp_s2_reg;
   logic rp_prev_reg;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_s1_reg <= pfs_pkg::PIN_SYNC_RESET;
         en_s2_reg <= pfs_pkg::PIN_SYNC_RESET;
         rp_s1_reg <= pfs_pkg::PIN_SYNC_RESET;
         rp_s2_reg <= pfs_pkg::PIN_SYNC_RESET;
         rp_prev_reg <= pfs_pkg::PIN_SYNC_RESET;
      end else begin
         en_s1_reg <= enable_pin_in;
         en_s2_reg <= en_s1_reg;
         rp_s1_reg <= reset_pin_in;
         rp_s2_reg <= rp_s1_reg;
         rp_prev_reg <= rp_s2_reg;
      end
   end
   logic rp_fall;
   assign rp_fall = rp_prev_reg && !rp_s2_reg;

   // per-channel detection flags, bit 2 interrupted, 1 timeout, 0 pass
   logic [2:0] prof_reg [NUM_CHANNELS];
   logic [2:0] prof_next [NUM_CHANNELS];
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_channel
         logic clr;
         logic pass_evt;
         assign clr = fb_read && (32'(req.channel_number) == g);
         // a completion racing an abort or expiry is not a pass
         assign pass_evt = detect_done_in[g] && !timeout_expired_in[g] && !gate_off_abort_in[g];
         always_comb begin
            prof_next[g] = clr ? 3'h0 : prof_reg[g];
            // set wins over the read clear, each bit on its own
            if (gate_off_abort_in[g]) begin
               prof_next[g][pfs_pkg::BIT_DETECT_INTRPT] = 1'b1;
            end
            if (timeout_expired_in[g]) begin
               prof_next[g][pfs_pkg::BIT_TIMEOUT] = 1'b1;
            end
            if (pass_evt) begin
               prof_next[g][pfs_pkg::BIT_PASS] = 1'b1;
            end
         end
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               prof_reg[g] <= pfs_pkg::PROFILE_FLAGS_RESET;
            end else begin
               prof_reg[g] <= prof_next[g];
            end
         end
      end
   endgenerate

   // generic flags
   logic overvoltage_flag_reg;
   logic overvoltage_flag_next;
   logic phase_sync_event_flag_reg;
   logic phase_sync_event_flag_next;
   logic enl_reg;
   logic enl_next;
   logic rpl_reg;
   logic rpl_next;
   always_comb begin
      overvoltage_flag_next = overvoltage_evt_in || (overvoltage_flag_reg && !gf_read);
      phase_sync_event_flag_next = phase_sync_evt_in || (phase_sync_event_flag_reg && !gf_read);
      if (!en_s2_reg) begin
         enl_next = 1'b1;
      end else if (gf_read) begin
         enl_next = 1'b0;
      end else begin
         enl_next = enl_reg;
      end
      rpl_next = rp_fall || (rpl_reg && !gf_read);
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         overvoltage_flag_reg <= pfs_pkg::OVERVOLTAGE_RESET;
         phase_sync_event_flag_reg <= pfs_pkg::PHASE_SYNC_RESET;
         enl_reg <= pfs_pkg::ENABLE_LATCH_RESET;
         rpl_reg <= pfs_pkg::RESET_PIN_LATCH_RESET;
      end else begin
         overvoltage_flag_reg <= overvoltage_flag_next;
         phase_sync_event_flag_reg <= phase_sync_event_flag_next;
         enl_reg <= enl_next;
         rpl_reg <= rpl_next;
      end
   end

   // answer shows flags as they stood before the read cleared them
   logic resp_valid_next;
   pfs_pkg::pfs_frame_type resp_next;
   pfs_pkg::pfs_frame_type resp_reg;
   always_comb begin
      resp_valid_next = fb_read || gf_read;
      resp_next = '0;
      if (fb_read) begin
         resp_next.message_identifier = pfs_pkg::MSG_PROFILE_FEEDBACK;
         resp_next.channel_number = req.channel_number;
         resp_next.data[2:0] = prof_reg[req.channel_number];
      end else if (gf_read) begin
         resp_next.message_identifier = pfs_pkg::MSG_GENERIC_FLAGS;
         resp_next.data[pfs_pkg::BIT_OVERVOLTAGE] = overvoltage_flag_reg;
         resp_next.data[pfs_pkg::BIT_PHASE_SYNC] = phase_sync_event_flag_reg;
         resp_next.data[pfs_pkg::BIT_ENABLE_LATCH] = enl_reg;
         resp_next.data[pfs_pkg::BIT_RESET_PIN_LATCH] = rpl_reg;
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         resp_valid_out <= 1'b0;
         resp_reg <= '0;
      end else begin
         resp_valid_out <= resp_valid_next;
         resp_reg <= resp_next;
      end
   end
   assign resp_frame_out = resp_reg;

   property p_fb_answer;
      @(posedge clk_in) disable iff (!nrst_in)
      fb_read |=> resp_valid_out && resp_frame_out[30:27] == 4'hb && resp_frame_out[26:24] == $past(req_frame_in[26:24]);
   endproperty
   a_fb_answer: assert property (p_fb_answer) else $error("feedback answer wrong");

   property p_zero_fill;
      @(posedge clk_in) disable iff (!nrst_in)
      resp_valid_out |-> !resp_frame_out[31] && resp_frame_out[23:4] == 20'h0_0000;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("unused answer bits not zero");

   property p_intrpt_set;
      @(posedge clk_in) disable iff (!nrst_in)
      gate_off_abort_in[0] |=> prof_reg[0][2];
   endproperty
   a_intrpt_set: assert property (p_intrpt_set) else $error("interrupted flag not set");

   property p_fb_clear;
      @(posedge clk_in) disable iff (!nrst_in)
      fb_read && req_frame_in[26:24] == 3'h0 && gate_off_abort_in[0] == 1'b0 && timeout_expired_in[0] == 1'b0 &&
         detect_done_in[0] == 1'b0 |=> prof_reg[0] == 3'h0;
   endproperty
   a_fb_clear: assert property (p_fb_clear) else $error("feedback read did not clear");

   property p_pass_only;
      @(posedge clk_in) disable iff (!nrst_in)
      $rose(prof_reg[0][0]) |-> $past(detect_done_in[0] && !timeout_expired_in[0] && !gate_off_abort_in[0]);
   endproperty
   a_pass_only: assert property (p_pass_only) else $error("pass without clean completion");

   property p_hold;
      @(posedge clk_in) disable iff (!nrst_in)
      prof_reg[1][1] && !(fb_read && req_frame_in[26:24] == 3'h1) |=> prof_reg[1][1];
   endproperty
   a_hold: assert property (p_hold) else $error("timeout flag lost between reads");

   property p_overvolt_event_wins;
      @(posedge clk_in) disable iff (!nrst_in)
      gf_read && overvoltage_evt_in |=> overvoltage_flag_reg ##1
         (!resp_valid_out || resp_frame_out[3] || !$past(gf_read));
   endproperty
   a_overvolt_event_wins: assert property (p_overvolt_event_wins) else $error("overvoltage lost on read");

   property p_enable_low;
      @(posedge clk_in) disable iff (!nrst_in)
      !en_s2_reg |=> enl_reg;
   endproperty
   a_enable_low: assert property (p_enable_low) else $error("enable latch not forced");

   property p_reset_edge;
      @(posedge clk_in) disable iff (!nrst_in)
      rp_s2_reg ##1 !rp_s2_reg |=> rpl_reg;
   endproperty
   a_reset_edge: assert property (p_reset_edge) else $error("reset pin edge not latched");

   property p_gf_answer;
      @(posedge clk_in) disable iff (!nrst_in)
      gf_read |=> resp_valid_out && resp_frame_out[30:24] == 7'h78 && resp_frame_out[3:0] ==
         {$past(overvoltage_flag_reg), $past(phase_sync_event_flag_reg), $past(enl_reg), $past(rpl_reg)};
   endproperty
   a_gf_answer: assert property (p_gf_answer) else $error("generic answer wrong");

   property p_timeout_set;
      @(posedge clk_in) disable iff (!nrst_in)
      timeout_expired_in[1] |=> prof_reg[1][pfs_pkg::BIT_TIMEOUT];
   endproperty
   a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");

   property p_pass_set;
      @(posedge clk_in) disable iff (!nrst_in)
      detect_done_in[3] && !timeout_expired_in[3] && !gate_off_abort_in[3] |=> prof_reg[3][pfs_pkg::BIT_PASS];
   endproperty
   a_pass_set: assert property (p_pass_set) else $error("clean completion not passed");

   property p_pass_clear;
      @(posedge clk_in) disable iff (!nrst_in)
      fb_read && req_frame_in[26:24] == 3'h3 && !detect_done_in[3] |=> !prof_reg[3][pfs_pkg::BIT_PASS];
   endproperty
   a_pass_clear: assert property (p_pass_clear) else $error("pass flag kept after read");

   property p_intrpt_kept;
      @(posedge clk_in) disable iff (!nrst_in)
      prof_reg[5][2] && !(fb_read && req_frame_in[26:24] == 3'h5) |=> prof_reg[5][2];
   endproperty
   a_intrpt_kept: assert property (p_intrpt_kept) else $error("interrupted flag lost between reads");

   property p_overvolt_set;
      @(posedge clk_in) disable iff (!nrst_in)
      overvoltage_evt_in |=> overvoltage_flag_reg;
   endproperty
   a_overvolt_set: assert property (p_overvolt_set) else $error("overvoltage not latched");

   property p_phase_sync_set;
      @(posedge clk_in) disable iff (!nrst_in)
      phase_sync_evt_in |=> phase_sync_event_flag_reg;
   endproperty
   a_phase_sync_set: assert property (p_phase_sync_set) else $error("phase sync not latched");

   property p_event_clear;
      @(posedge clk_in) disable iff (!nrst_in)
      gf_read && !overvoltage_evt_in && !phase_sync_evt_in |=>
         !overvoltage_flag_reg && !phase_sync_event_flag_reg;
   endproperty
   a_event_clear: assert property (p_event_clear) else $error("event flags kept after read");

   property p_enable_clear;
      @(posedge clk_in) disable iff (!nrst_in)
      gf_read && en_s2_reg |=> !enl_reg;
   endproperty
   a_enable_clear: assert property (p_enable_clear) else $error("enable latch kept after read");

   property p_reset_latch_clear;
      @(posedge clk_in) disable iff (!nrst_in)
      gf_read && !rp_fall |=> !rpl_reg;
   endproperty
   a_reset_latch_clear: assert property (p_reset_latch_clear) else $error("reset pin latch kept");

   property p_fb_zero_fill;
      @(posedge clk_in) disable iff (!nrst_in)
      resp_valid_out && resp_frame_out[30:27] == 4'hb |-> resp_frame_out[23:3] == '0;
   endproperty
   a_fb_zero_fill: assert property (p_fb_zero_fill) else $error("feedback unused bits not zero");

   property p_gf_zero_fill;
      @(posedge clk_in) disable iff (!nrst_in)
      resp_valid_out && resp_frame_out[30:27] == 4'hf |-> resp_frame_out[26:4] == '0;
   endproperty
   a_gf_zero_fill: assert property (p_gf_zero_fill) else $error("generic unused bits not zero");

   property p_no_stray_answer;
      @(posedge clk_in) disable iff (!nrst_in)
      !(fb_read || gf_read) |=> !resp_valid_out;
   endproperty
   a_no_stray_answer: assert property (p_no_stray_answer) else $error("answer without a known request");
endmodule
`default_nettype wire

// [pkg/pfs_pkg.sv]
/*
 * constants, field layout and frame carrier for the profile and flag status block.
 * assumes a 32-bit serial frame already assembled by a shifter on the same clock.
 */
package pfs_pkg;
   localparam int FRAME_W = 32;
   localparam int NUM_CHANNELS = 8;
   localparam int CHANNEL_W = 3;
   localparam logic [3:0] MSG_PROFILE_FEEDBACK = 4'hb;
   localparam logic [3:0] MSG_GENERIC_FLAGS = 4'hf;
   localparam int BIT_DETECT_INTRPT = 2;
   localparam int BIT_TIMEOUT = 1;
   localparam int BIT_PASS = 0;
   localparam int BIT_OVERVOLTAGE = 3;
   localparam int BIT_PHASE_SYNC = 2;
   localparam int BIT_ENABLE_LATCH = 1;
   localparam int BIT_RESET_PIN_LATCH = 0;
   localparam logic [2:0] PROFILE_FLAGS_RESET = 3'h0;
   localparam logic OVERVOLTAGE_RESET = 1'b0;
   localparam logic PHASE_SYNC_RESET = 1'b0;
   localparam logic ENABLE_LATCH_RESET = 1'b1;
   localparam logic RESET_PIN_LATCH_RESET = 1'b1;
   localparam logic PIN_SYNC_RESET = 1'b1;

   typedef struct packed {
      logic rw;
      logic [3:0] message_identifier;
      logic [CHANNEL_W-1:0] channel_number;
      logic [23:0] data;
   } pfs_frame_type;
endpackage

// [testbench/pfs_host.sv]
/*
 * host side model: issues one 32-bit read frame at a time and captures the answer.
 * assumes the status block answers on the taking edge itself, same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pfs_host (
   input wire logic clk_in, // system clock
   output logic req_valid_out, // frame strobe to the device
   output logic [31:0] req_frame_out, // frame to the device
   input wire logic resp_valid_in, // answer strobe
   input wire logic [31:0] resp_frame_in // answer frame
);
   initial begin
      req_valid_out = 1'b0;
      req_frame_out = 32'h0000_0000;
   end

   task automatic xfer(input logic [3:0] id, input logic [2:0] ch, output logic got, output logic [31:0] resp);
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b1;
      req_frame_out = {1'b0, id, ch, 24'h00_0000};
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b0;
      // released frame shows garbage, not the old value
      req_frame_out = ~req_frame_out;
      got = resp_valid_in;
      resp = resp_frame_in;
   endtask
endmodule
`default_nettype wire

// [testbench/pfs_status_tb.sv]
/*
 * self-checking bench for the profile and flag status block.
 * assumes the host model in pfs_host and one 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module pfs_status_tb;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] abort_r = 8'h00, tmo_r = 8'h00, done_r = 8'h00;
   logic overvolt_r = 1'b0, sync_r = 1'b0, en_r = 1'b1, rb_r = 1'b1;
   logic req_valid, resp_valid, got;
   logic [31:0] req_frame, resp_frame, rsp;
   logic [2:0] exp_prof [8] = '{3'h5, 3'h2, 3'h0, 3'h1, 3'h0, 3'h5, 3'h6, 3'h2};
   int failures = 0, num_checks = 0, cycles = 0;

   always #2 clk_in = ~clk_in;

   pfs_host u_pfs_host (.clk_in(clk_in), .req_valid_out(req_valid), .req_frame_out(req_frame),
      .resp_valid_in(resp_valid), .resp_frame_in(resp_frame));
   pfs_status u_pfs_status (.clk_in(clk_in), .nrst_in(nrst_in), .req_valid_in(req_valid),
      .req_frame_in(req_frame), .resp_valid_out(resp_valid), .resp_frame_out(resp_frame),
      .gate_off_abort_in(abort_r), .timeout_expired_in(tmo_r), .detect_done_in(done_r),
      .overvoltage_evt_in(overvolt_r), .phase_sync_evt_in(sync_r), .enable_pin_in(en_r), .reset_pin_in(rb_r));

   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      // whole run needs well under a thousand cycles
      if (cycles == 3000) begin
         failures++;
         $display("ERROR %0t timeout", $time);
         complete_run();
      end
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic gen_read(input logic [3:0] exp);
      logic g;
      logic [31:0] r;
      u_pfs_host.xfer(pfs_pkg::MSG_GENERIC_FLAGS, 3'h0, g, r);
      `CHK(g, 1'b1)
      `CHK(r, {1'b0, pfs_pkg::MSG_GENERIC_FLAGS, 23'h0, exp})
   endtask

   task automatic prof_read(input logic [2:0] ch, input logic [2:0] exp);
      logic g;
      logic [31:0] r;
      u_pfs_host.xfer(pfs_pkg::MSG_PROFILE_FEEDBACK, ch, g, r);
      `CHK(g, 1'b1)
      `CHK(r, {1'b0, pfs_pkg::MSG_PROFILE_FEEDBACK, ch, 21'h0, exp})
   endtask

   task automatic pulse(input logic [7:0] a, t, d, input logic o, p);
      @(posedge clk_in);
      #1;
      {abort_r, tmo_r, done_r, overvolt_r, sync_r} = {a, t, d, o, p};
      @(posedge clk_in);
      #1;
      {abort_r, tmo_r, done_r, overvolt_r, sync_r} = '0;
   endtask

   initial begin
      wait_cyc(2);
      nrst_in = 1'b1;
      gen_read(4'b0011);
      gen_read(4'b0000);
      for (int c = 0; c < 8; c++) prof_read(c[2:0], 3'h0);
      $display("test reset values done");
      // ch0 abort then pass, ch1 timeout, ch3 pass, ch5 abort then pass, ch6 abort with timeout, ch7 timeout
      pulse(8'h61, 8'hc2, 8'h08, 1'b0, 1'b0);
      pulse(8'h00, 8'h00, 8'h21, 1'b0, 1'b0);
      for (int c = 0; c < 8; c++) prof_read(c[2:0], exp_prof[c]);
      for (int c = 0; c < 8; c++) prof_read(c[2:0], 3'h0);
      // an abort landing on the read edge must survive the clear
      fork
         u_pfs_host.xfer(pfs_pkg::MSG_PROFILE_FEEDBACK, 3'h2, got, rsp);
         pulse(8'h04, 8'h00, 8'h00, 1'b0, 1'b0);
      join
      `CHK(got, 1'b1)
      `CHK(rsp, {1'b0, pfs_pkg::MSG_PROFILE_FEEDBACK, 3'h2, 24'h00_0000})
      prof_read(3'h2, 3'h4);
      prof_read(3'h2, 3'h0);
      $display("test detection flags done");
      // events landing on the read edge must survive the clear
      fork
         u_pfs_host.xfer(pfs_pkg::MSG_GENERIC_FLAGS, 3'h0, got, rsp);
         pulse(8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
      join
      `CHK(got, 1'b1)
      `CHK(rsp[3:0], 4'b0000)
      gen_read(4'b1100);
      gen_read(4'b0000);
      $display("test event flags done");
      en_r = 1'b0;
      wait_cyc(5);
      gen_read(4'b0010);
      gen_read(4'b0010);
      en_r = 1'b1;
      wait_cyc(5);
      gen_read(4'b0010);
      gen_read(4'b0000);
      rb_r = 1'b0;
      wait_cyc(5);
      rb_r = 1'b1;
      wait_cyc(5);
      gen_read(4'b0001);
      gen_read(4'b0000);
      $display("test pin latches done");
      u_pfs_host.xfer(4'ha, 3'h1, got, rsp);
      `CHK(got, 1'b0)
      $display("test unknown id done");
      complete_run();
   end
endmodule
`default_nettype wire
